/* File: hdl/hs_pkg.sv */
// Constants and types shared by the homing sequencer.
package hs_pkg;

    // ********************************************************************
    // Homing method codes
    // ********************************************************************
    localparam logic [7:0] METHOD_IDX_NEG_FWD   = 8'h0B;
    localparam logic [7:0] METHOD_IDX_NEG_RET   = 8'h0C;
    localparam logic [7:0] METHOD_IDX_NEG_TURN  = 8'h0D;
    localparam logic [7:0] METHOD_IDX_NEG_THRU  = 8'h0E;
    localparam logic [7:0] METHOD_NEG_LIMIT     = 8'h11;
    localparam logic [7:0] METHOD_POS_LIMIT     = 8'h12;
    localparam logic [7:0] METHOD_SW_POS        = 8'h13;
    localparam logic [7:0] METHOD_SW_POS_SLOW   = 8'h14;
    localparam logic [7:0] METHOD_SW_NEG        = 8'h15;
    localparam logic [7:0] METHOD_SW_NEG_SLOW   = 8'h16;
    localparam logic [7:0] METHOD_SW_POS_LIMIT  = 8'h17;

    localparam int SPEED_W = 16;

    // ********************************************************************
    // Sequencer states
    // ********************************************************************
    typedef enum logic [2:0] {
        HS_IDLE     = 3'b000,
        HS_FAST     = 3'b001,
        HS_BOUNCE   = 3'b010,
        HS_SLOW1    = 3'b011,
        HS_SLOW2    = 3'b100,
        HS_SEEK_IDX = 3'b101,
        HS_DONE     = 3'b110
    } hs_state_e;

    // Event that ends the current phase.
    typedef enum logic [2:0] {
        EV_NONE  = 3'b000,
        EV_RISE  = 3'b001,
        EV_FALL  = 3'b010,
        EV_INDEX = 3'b011,
        EV_STOP  = 3'b100
    } hs_event_e;

endpackage

/* File: hdl/hs_homing_sequencer.sv */
// Homing sequencer choosing direction and speed for each homing phase.

// Behaviour
// - Method 11, switch low, no limit: negative fast, at switch edge positive slow.
// - Method 11, negative limit met: positive fast, at switch rise slow positive.
// - Method 11, switch active at start: positive slow, halt at index after fall.
// - Method 12: negative fast, rise positive slow, fall negative slow, halt index.
// - Method 13: negative, slow at rise, fall positive slow, halt at index.
// - Method 14: negative except positive fast after a limit reversal, slow at rise, past fall, halt at index.
// - Negative limit homing, limit inactive: negative fast, rise positive slow, halt fall.
// - Negative limit homing, limit active at start: positive slow directly.
// - Positive limit homing, limit inactive: positive fast, rise negative slow, halt fall.
// - Positive limit homing, limit active at start: negative slow directly.
// - Switch search positive: fast positive, rise negative slow, halt fall.
// - Slow positive switch method, switch inactive: positive slow, halt at rise.
// - Slow positive switch method, switch active: negative fast, fall positive slow.
// - Switch search negative: fast negative, rise positive slow, halt fall.
// - Slow negative switch method, switch inactive: negative slow, halt at rise.
// - Slow negative switch method, switch active: positive fast, fall negative slow.
// - Limit-aware positive: positive fast, rise negative slow, halt at fall.
// - Limit-aware positive, positive limit met: negative fast, rise slow negative.
// - Limit-aware positive, switch active at start: negative slow, halt at fall.
// - Deceleration-point level sampled at start selects the motion sequence.
module hs_homing_sequencer (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       start,
    input  wire logic [7:0]                 homing_method_select,
    input  wire logic [hs_pkg::SPEED_W-1:0] high_speed,
    input  wire logic [hs_pkg::SPEED_W-1:0] low_speed,
    input  wire logic                       home_reference_switch,
    input  wire logic                       negative_travel_limit,
    input  wire logic                       positive_travel_limit,
    input  wire logic                       encoder_index,
    output logic                            moving,
    output logic                            dir_negative,
    output logic [hs_pkg::SPEED_W-1:0]      speed,
    output logic                            done,
    output logic                            busy
);

    // ********************************************************************
    // Input synchronisers
    // ********************************************************************
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;

    // Two flops guard against metastability on the asynchronous pins.
    // The third holds the last settled level for edge detection.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1 <= 4'h0;
        end else begin
            sync1 <= {encoder_index, positive_travel_limit,
                      negative_travel_limit, home_reference_switch};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync2 <= 4'h0;
        end else begin
            sync2 <= sync1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prev <= 4'h0;
        end else begin
            prev <= sync2;
        end
    end

    wire logic sw     = sync2[0];
    wire logic nlim   = sync2[1];
    wire logic plim   = sync2[2];
    wire logic sw_r   = sync2[0] & ~prev[0];
    wire logic sw_f   = ~sync2[0] & prev[0];
    wire logic nl_r   = sync2[1] & ~prev[1];
    wire logic nl_f   = ~sync2[1] & prev[1];
    wire logic pl_r   = sync2[2] & ~prev[2];
    wire logic pl_f   = ~sync2[2] & prev[2];
    wire logic idx_r  = sync2[3] & ~prev[3];

    // ********************************************************************
    // Method decode
    // ********************************************************************
    logic [7:0] method;
    // The method is captured on every idle cycle, so it is fixed once a
    // run starts even if the selection moves afterwards.
    wire logic m11  = method == hs_pkg::METHOD_IDX_NEG_FWD;
    wire logic m12  = method == hs_pkg::METHOD_IDX_NEG_RET;
    wire logic m13  = method == hs_pkg::METHOD_IDX_NEG_TURN;
    wire logic m14  = method == hs_pkg::METHOD_IDX_NEG_THRU;
    wire logic mnl  = method == hs_pkg::METHOD_NEG_LIMIT;
    wire logic mpl  = method == hs_pkg::METHOD_POS_LIMIT;
    wire logic msp  = method == hs_pkg::METHOD_SW_POS;
    wire logic msps = method == hs_pkg::METHOD_SW_POS_SLOW;
    wire logic msn  = method == hs_pkg::METHOD_SW_NEG;
    wire logic msns = method == hs_pkg::METHOD_SW_NEG_SLOW;
    wire logic mspl = method == hs_pkg::METHOD_SW_POS_LIMIT;
    wire logic m_idx = m11 | m12 | m13 | m14;
    wire logic m_sw_neg_first = m11 | m12 | m13 | m14 | msn;

    // Deceleration-point input for the selected method.
    wire logic [7:0] sel_method = homing_method_select;
    wire logic decel_now =
        (sel_method == hs_pkg::METHOD_NEG_LIMIT) ? nlim :
        (sel_method == hs_pkg::METHOD_POS_LIMIT) ? plim : sw;
    wire logic method_ok =
        (sel_method >= hs_pkg::METHOD_IDX_NEG_FWD &&
         sel_method <= hs_pkg::METHOD_IDX_NEG_THRU) ||
        (sel_method >= hs_pkg::METHOD_NEG_LIMIT &&
         sel_method <= hs_pkg::METHOD_SW_POS_LIMIT);

    // Edges on the deceleration-point signal of the running method.
    wire logic dp_r = mnl ? nl_r : (mpl ? pl_r : sw_r);
    wire logic dp_f = mnl ? nl_f : (mpl ? pl_f : sw_f);
    // Travel limit that forces a fast reversal during the fast search.
    wire logic lim_hit = (m_sw_neg_first & nlim) | (mspl & plim);

    // ********************************************************************
    // Phase sequencing
    // ********************************************************************
    hs_pkg::hs_state_e state;
    hs_pkg::hs_state_e next_state;
    logic              next_dir;
    logic              next_fast;
    logic              dir_r;
    logic              fast_r;
    logic              next_done;

    always_comb begin
        next_state = state;
        next_dir   = dir_r;
        next_fast  = fast_r;
        next_done  = 1'b0;
        case (state)
            hs_pkg::HS_IDLE: begin
                if (start && method_ok) begin
                    // Level at start picks the sequence.
                    if (!decel_now) begin
                        next_fast  = ~(msps | msns);
                        next_dir   = m_sw_neg_first | mnl | msns;
                        next_state = (msps | msns) ? hs_pkg::HS_SLOW2
                                                   : hs_pkg::HS_FAST;
                    end else if (msps | msns) begin
                        next_fast  = 1'b1;
                        next_dir   = msps;
                        next_state = hs_pkg::HS_BOUNCE;
                    end else begin
                        next_fast  = 1'b0;
                        next_dir   = m13 | m14 | mpl | msp | mspl;
                        next_state = hs_pkg::HS_SLOW1;
                    end
                end
            end
            hs_pkg::HS_FAST: begin
                if (!m_idx && !mspl && dp_r) begin
                    next_fast  = 1'b0;
                    next_dir   = ~dir_r;
                    next_state = hs_pkg::HS_SLOW1;
                end else if (dp_r) begin
                    next_fast  = 1'b0;
                    next_dir   = (m13 | m14) ? dir_r : ~dir_r;
                    next_state = hs_pkg::HS_SLOW1;
                end else if (lim_hit) begin
                    next_dir   = ~dir_r;
                    next_state = hs_pkg::HS_BOUNCE;
                end
            end
            hs_pkg::HS_BOUNCE: begin
                if ((msps | msns) ? sw_f : sw_r) begin
                    // After a limit reversal the index variants whose slow search is
                    // negative (13 and 14) turn back here; the others keep going.
                    next_fast  = 1'b0;
                    next_dir   = (msps | msns) ? ~dir_r
                               : ((m13 | m14) ? 1'b1 : dir_r);
                    next_state = hs_pkg::HS_SLOW1;
                end
            end
            hs_pkg::HS_SLOW1: begin
                if (dp_f) begin
                    if (m11) begin
                        next_state = hs_pkg::HS_SEEK_IDX;
                    end else if (m12 | m13) begin
                        next_dir   = ~dir_r;
                        next_state = hs_pkg::HS_SEEK_IDX;
                    end else if (m14) begin
                        next_state = hs_pkg::HS_SEEK_IDX;
                    end else if (!(msps | msns)) begin
                        next_state = hs_pkg::HS_DONE;
                    end
                end
            end
            hs_pkg::HS_SLOW2: begin
                if (sw_r) begin
                    next_state = hs_pkg::HS_DONE;
                end
            end
            hs_pkg::HS_SEEK_IDX: begin
                if (idx_r) begin
                    next_state = hs_pkg::HS_DONE;
                end
            end
            hs_pkg::HS_DONE: begin
                next_done  = 1'b1;
                next_state = hs_pkg::HS_IDLE;
            end
            default: begin
                next_state = hs_pkg::HS_IDLE;
            end
        endcase
    end

    wire logic next_moving = (next_state != hs_pkg::HS_IDLE) &&
                             (next_state != hs_pkg::HS_DONE);
    // Speed is zero whenever the axis is not commanded to move.
    wire logic [hs_pkg::SPEED_W-1:0] next_speed =
        !next_moving ? '0 : (next_fast ? high_speed : low_speed);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= hs_pkg::HS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dir_r <= 1'b0;
        end else begin
            dir_r <= next_dir;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fast_r <= 1'b0;
        end else begin
            fast_r <= next_fast;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            method <= 8'h00;
        end else if (state == hs_pkg::HS_IDLE) begin
            method <= sel_method;
        end
    end

    // ********************************************************************
    // Output registers
    // ********************************************************************
    // Every output is a flop so the drive sees clean levels.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            moving <= 1'b0;
        end else begin
            moving <= next_moving;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dir_negative <= 1'b0;
        end else begin
            dir_negative <= next_dir;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            speed <= '0;
        end else begin
            speed <= next_speed;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done <= 1'b0;
        end else begin
            done <= next_done;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
        end else begin
            busy <= next_state != hs_pkg::HS_IDLE;
        end
    end

endmodule

/* File: testbench/hs_homing_sequencer_chk.sv */
// Port assertions for the homing sequencer.
module hs_homing_sequencer_chk (
    input wire logic                       clk,
    input wire logic                       reset,
    input wire logic                       start,
    input wire logic [7:0]                 homing_method_select,
    input wire logic [hs_pkg::SPEED_W-1:0] high_speed,
    input wire logic [hs_pkg::SPEED_W-1:0] low_speed,
    input wire logic                       home_reference_switch,
    input wire logic                       negative_travel_limit,
    input wire logic                       positive_travel_limit,
    input wire logic                       encoder_index,
    input wire logic                       moving,
    input wire logic                       dir_negative,
    input wire logic [hs_pkg::SPEED_W-1:0] speed,
    input wire logic                       done,
    input wire logic                       busy
);
    timeunit 1ns;
    timeprecision 1ns;
    // Ages count cycles since any pin last changed, or since the index was last high.
    logic [3:0] pins_q;
    logic [7:0] pin_age;
    logic [7:0] idx_age;
    wire  [3:0] pins = {home_reference_switch, negative_travel_limit,
                        positive_travel_limit, encoder_index};
    wire  [7:0] next_pin_age = (pins != pins_q) ? 8'h00 :
                               pin_age + {7'h00, pin_age != 8'hFF};
    wire  [7:0] next_idx_age = encoder_index ? 8'h00 :
                               idx_age + {7'h00, idx_age != 8'hFF};
    wire        idx_mth = homing_method_select inside {[8'h0B:8'h0E]};
    wire        hm_ok = idx_mth || homing_method_select inside {[8'h11:8'h17]};
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pins_q <= 4'h0;
            pin_age <= 8'hFF;
            idx_age <= 8'hFF;
        end else begin
            pins_q <= pins;
            pin_age <= next_pin_age;
            idx_age <= next_idx_age;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    idle_quiet_a: assert property (!busy |-> !moving && speed == '0)
        else $error("motion while idle");
    start_go_a: assert property (!busy && start && hm_ok &&
        $stable(homing_method_select) |=> busy && moving)
        else $error("valid start not taken");
    bad_method_a: assert property (!busy && start && !hm_ok |=> !busy)
        else $error("invalid method started a run");
    speed_pick_a: assert property (moving |->
        speed == high_speed || speed == low_speed)
        else $error("speed is neither search value");
    done_pulse_a: assert property (done |=> !done && !busy)
        else $error("done not a single closing cycle");
    done_still_a: assert property (done |-> !moving && speed == '0)
        else $error("moving at done");
    index_halt_a: assert property (done && idx_mth |-> idx_age < 8'd8)
        else $error("index method halted without index");
    phase_cause_a: assert property (busy && $past(busy) &&
        $changed({dir_negative, speed}) |-> pin_age < 8'd8)
        else $error("phase changed without pin event");
endmodule
bind hs_homing_sequencer hs_homing_sequencer_chk u_hs_homing_sequencer_chk (.*);

/* File: testbench/hs_pins_model.sv */
// Model of the home switch, travel limits and encoder index.
module hs_pins_model (
    input  wire logic clk,
    output logic      home_reference_switch,
    output logic      negative_travel_limit,
    output logic      positive_travel_limit,
    output logic      encoder_index
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {home_reference_switch, negative_travel_limit} = 2'b00;
        {positive_travel_limit, encoder_index} = 2'b00;
    end
    // Sets a pin at the falling edge; pin 3 gives a two-cycle index pulse.
    task automatic drive(input int pin, input logic lvl);
        @(negedge clk);
        case (pin)
            0: home_reference_switch = lvl;
            1: negative_travel_limit = lvl;
            2: positive_travel_limit = lvl;
            default: begin
                encoder_index = 1'b1;
                repeat (2) @(negedge clk);
                encoder_index = 1'b0;
            end
        endcase
    endtask
endmodule

/* File: testbench/hs_homing_sequencer_tb_top.sv */
// Self-checking testbench for the homing sequencer.
module hs_homing_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] HI = 16'h0A5C;
    localparam logic [15:0] LO = 16'h0013;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        start = 1'b0;
    logic [7:0]  homing_method_select = 8'h00;
    logic [15:0] high_speed = HI;
    logic [15:0] low_speed = LO;
    wire         home_reference_switch, negative_travel_limit;
    wire         positive_travel_limit, encoder_index;
    logic        moving, dir_negative, done, busy;
    logic [15:0] speed;
    int          num_errors = 0;
    int          comparisons = 0;
    int          dones = 0;
    always #5 clk = ~clk;
    always @(negedge clk) if (done === 1'b1) dones++;
    hs_homing_sequencer u_hs_homing_sequencer (.*);
    hs_pins_model u_hs_pins_model (.*);
    // ********************************************************************
    // Shared tasks
    // ********************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic look(input logic m, input logic n, input int s);
        repeat (6) @(negedge clk);
        check({moving, dir_negative & m, speed},
              {m, n & m, s == 2 ? HI : (s == 1 ? LO : 16'h0000)});
    endtask
    task automatic st(input int p, input logic v, input logic m,
                      input logic n, input int s);
        u_hs_pins_model.drive(p, v);
        look(m, n, s);
    endtask
    // Sets the pins and method while idle, then starts a run.
    task automatic go(input logic [7:0] mth, input logic [2:0] pins,
                      input logic n, input int s);
        u_hs_pins_model.drive(0, pins[0]);
        u_hs_pins_model.drive(1, pins[1]);
        u_hs_pins_model.drive(2, pins[2]);
        homing_method_select = mth;
        repeat (4) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        check(busy, 1'b1);
        look(1'b1, n, s);
    endtask
    task automatic halt(input int p, input logic v);
        int d;
        d = dones;
        st(p, v, 1'b0, 1'b0, 0);
        check(dones, d + 1);
        check(busy, 1'b0);
    endtask
    task automatic rst;
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        check({busy, moving}, 2'b00);
    endtask
    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic t_index;
        go(8'h0B, 3'b000, 1, 2);
        st(0, 1, 1, 0, 1);
        st(0, 0, 1, 0, 1);
        halt(3, 1);
        go(8'h0B, 3'b000, 1, 2);
        st(1, 1, 1, 0, 2);
        st(1, 0, 1, 0, 2);
        st(0, 1, 1, 0, 1);
        st(0, 0, 1, 0, 1);
        halt(3, 1);
        go(8'h0B, 3'b001, 0, 1);
        st(3, 1, 1, 0, 1);
        st(0, 0, 1, 0, 1);
        halt(3, 1);
        go(8'h0C, 3'b000, 1, 2);
        st(0, 1, 1, 0, 1);
        st(0, 0, 1, 1, 1);
        halt(3, 1);
        go(8'h0D, 3'b000, 1, 2);
        st(0, 1, 1, 1, 1);
        st(0, 0, 1, 0, 1);
        halt(3, 1);
        go(8'h0E, 3'b000, 1, 2);
        st(0, 1, 1, 1, 1);
        st(0, 0, 1, 1, 1);
        halt(3, 1);
    endtask
    task automatic t_limits;
        go(8'h11, 3'b000, 1, 2);
        st(1, 1, 1, 0, 1);
        halt(1, 0);
        go(8'h11, 3'b010, 0, 1);
        halt(1, 0);
        go(8'h12, 3'b000, 0, 2);
        st(2, 1, 1, 1, 1);
        halt(2, 0);
        go(8'h12, 3'b100, 1, 1);
        halt(2, 0);
    endtask
    task automatic t_switch;
        go(8'h13, 3'b000, 0, 2);
        st(0, 1, 1, 1, 1);
        halt(0, 0);
        go(8'h13, 3'b001, 1, 1);
        halt(0, 0);
        go(8'h14, 3'b000, 0, 1);
        halt(0, 1);
        go(8'h14, 3'b001, 1, 2);
        st(0, 0, 1, 0, 1);
        rst;
        go(8'h15, 3'b000, 1, 2);
        st(0, 1, 1, 0, 1);
        halt(0, 0);
        go(8'h15, 3'b001, 0, 1);
        halt(0, 0);
        go(8'h16, 3'b000, 1, 1);
        halt(0, 1);
        go(8'h16, 3'b001, 0, 2);
        st(0, 0, 1, 1, 1);
        rst;
    endtask
    task automatic t_limit_aware;
        go(8'h17, 3'b000, 0, 2);
        st(0, 1, 1, 1, 1);
        halt(0, 0);
        go(8'h17, 3'b000, 0, 2);
        st(2, 1, 1, 1, 2);
        st(2, 0, 1, 1, 2);
        st(0, 1, 1, 1, 1);
        halt(0, 0);
        go(8'h17, 3'b001, 1, 1);
        halt(0, 0);
        homing_method_select = 8'h10;
        repeat (2) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        look(0, 0, 0);
    endtask
    task automatic end_sim;
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        end_sim;
    end
    initial begin
        repeat (12) @(negedge clk);
        reset = 1'b0;
        t_index;
        t_limits;
        t_switch;
        t_limit_aware;
        end_sim;
    end
endmodule
